//--- dps_pkg.sv
// Constants and types for the default power sequence launcher
package dps_pkg;
   // Timing
   localparam int CLK_PERIOD_NS    = 100;
   localparam int STEP_UNIT_NS     = 1_000_000;
   localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] ADR_SEQ_CTRL = 8'h00;
   localparam logic [7:0] ADR_SEQ_STAT = 8'h04;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADR_IRQ_CLR  = 8'h0C;
   localparam logic [7:0] ADR_IRQ_EN   = 8'h10;
   localparam logic [7:0] ADR_MEM_ADR  = 8'h14;
   localparam logic [7:0] ADR_MEM_DAT  = 8'h18;

   // Field positions
   localparam int CTRL_EN_BIT    = 15;
   localparam int CTRL_ABORT_BIT = 9;
   localparam int CTRL_START_BIT = 8;
   localparam int STAT_IDX_LSB   = 4;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_ABORT_BIT  = 1;
   localparam int IRQ_W          = 2;
   localparam int IDX_W          = 7;
   localparam int MEM_DEPTH      = 128;

   // Reset values
   localparam logic [15:0]      CTRL_RST    = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 2'h0;
   localparam logic [IDX_W-1:0] MEM_ADR_RST = 7'h00;

   // Launch words and start indices of the stored sequences
   localparam logic [15:0] LAUNCH_CLASSD_ON   = 16'h8100;
   localparam logic [15:0] LAUNCH_CLASSD_OFF  = 16'h8115;
   localparam logic [15:0] LAUNCH_LINE_ON     = 16'h812A;
   localparam logic [15:0] LAUNCH_LINE_OFF    = 16'h813F;
   localparam logic [15:0] LAUNCH_CLASSAB_ON  = 16'h8154;
   localparam logic [15:0] LAUNCH_CLASSAB_OFF = 16'h8169;
   localparam logic [IDX_W-1:0] IDX_CLASSD_ON   = 7'h00;
   localparam logic [IDX_W-1:0] IDX_CLASSD_OFF  = 7'h15;
   localparam logic [IDX_W-1:0] IDX_LINE_ON     = 7'h2A;
   localparam logic [IDX_W-1:0] IDX_LINE_OFF    = 7'h3F;
   localparam logic [IDX_W-1:0] IDX_CLASSAB_ON  = 7'h54;
   localparam logic [IDX_W-1:0] IDX_CLASSAB_OFF = 7'h69;

   // Typical run times and step delays, in milliseconds
   localparam int CLASSD_ON_MS   = 42;
   localparam int CLASSD_OFF_MS  = 48;
   localparam int LINE_ON_MS     = 550;
   localparam int LINE_OFF_MS    = 646;
   localparam int CLASSAB_ON_MS  = 42;
   localparam int CLASSAB_OFF_MS = 49;
   localparam int DLY_SHORT_MS   = 10;
   localparam int DLY_REF_MS     = 20;
   localparam int DLY_LONG_MS    = 400;

   typedef struct packed {
      logic bias_en;
      logic midrail_reference_soft;
      logic spk_classd;
      logic spk_classab;
      logic dac_en;
      logic dac_mute;
      logic line_en;
      logic line_clamp;
      logic line_discharge;
   } dps_act_t;

   typedef struct packed {
      logic       eos;
      logic [9:0] delay_ms;
      dps_act_t   act;
   } dps_step_t;

   localparam int STEP_W = $bits(dps_step_t);

   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_WAIT} dps_state_t;
endpackage

//--- dps_sequencer.sv
// Power sequence launcher: write sequencer, step memory, power-on reset, Wishbone slave
// Notes on behaviour
// - 8100h launches Class D enable, index 0
// - 8115h launches Class D disable, index 21
// - 812Ah launches line output enable, index 42
// - 813Fh launches line output disable, index 63
// - 8154h launches Class AB enable, index 84
// - 8169h launches Class AB disable, index 105
// - Class D enable leaves line clamped
// - Class D disable discharges line, drops bias
// - Line enable discharges first, then powers up
// - Line disable discharges line, drops bias
// - Class AB enable leaves line clamped
// - Class AB disable discharges line, drops bias
// - Reset low while either supply is low
// - Writes ignored while power-on reset low
// - Defaults restored, writes accepted after release
// - Start bit launches at index when enabled
// - End of sequence clears start bit
`timescale 1ns/1ns
module dps_sequencer
   import dps_pkg::*;
#(
   parameter int UNIT_CYCLES = STEP_UNIT_CYCLES
) (
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic             wb_ack_out,
   output logic [31:0]      wb_dat_out,
   input  wire logic        analogue_supply_ok_in,
   input  wire logic        core_supply_ok_in,
   output logic             power_on_reset_n_out,
   output dps_act_t         act_out,
   output logic             sequencer_running_flag_out,
   output logic             irq_out
);

   localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYCLES - 1);

   // Speaker enable: reference first, driver, DAC, then unmute and clamp
   function automatic dps_step_t on_step(input int k, input dps_act_t drv, input int total);
      dps_step_t s;
      s = '0;
      s.act.bias_en   = 1'b1;
      s.act.midrail_reference_soft = 1'b1;
      s.act.dac_mute  = 1'b1;
      if (k >= 1) begin
         s.act = s.act | drv;
      end
      if (k >= 2) begin
         s.act.dac_en = 1'b1;
      end
      unique case (k)
         0: s.delay_ms = 10'(DLY_REF_MS);
         1, 2: s.delay_ms = 10'(DLY_SHORT_MS);
         3: begin
            s.act.dac_mute   = 1'b0;
            s.act.line_clamp = 1'b1;
            s.eos            = 1'b1;
            s.delay_ms       = 10'(total - DLY_REF_MS - 2 * DLY_SHORT_MS);
         end
         default: s = '0;
      endcase
      return s;
   endfunction

   // Disable: mute, then driver and DAC off with line discharge, then bias off
   function automatic dps_step_t off_step(input int k, input dps_act_t drv, input int total);
      dps_step_t s;
      s = '0;
      unique case (k)
         0: begin
            s.act           = drv;
            s.act.dac_en    = 1'b1;
            s.act.dac_mute  = 1'b1;
            s.act.bias_en   = 1'b1;
            s.act.midrail_reference_soft = 1'b1;
            s.delay_ms      = 10'(DLY_SHORT_MS);
         end
         1: begin
            s.act.dac_mute       = 1'b1;
            s.act.line_discharge = 1'b1;
            s.act.bias_en        = 1'b1;
            s.act.midrail_reference_soft      = 1'b1;
            s.delay_ms           = 10'(DLY_REF_MS);
         end
         2: begin
            s.act.line_discharge = 1'b1;
            s.eos                = 1'b1;
            s.delay_ms           = 10'(total - DLY_SHORT_MS - DLY_REF_MS);
         end
         default: s = '0;
      endcase
      return s;
   endfunction

   // Line enable: discharge, soft reference ramp, power path, unmute
   function automatic dps_step_t line_on_step(input int k);
      dps_step_t s;
      s = '0;
      unique case (k)
         0: begin
            s.act.line_discharge = 1'b1;
            s.delay_ms           = 10'(DLY_REF_MS);
         end
         1: begin
            s.act.bias_en   = 1'b1;
            s.act.midrail_reference_soft = 1'b1;
            s.delay_ms      = 10'(DLY_LONG_MS);
         end
         2, 3: begin
            s.act.bias_en   = 1'b1;
            s.act.midrail_reference_soft = 1'b1;
            s.act.line_en   = 1'b1;
            s.act.dac_en    = 1'b1;
            s.act.dac_mute  = (k == 2);
            s.eos           = (k == 3);
            s.delay_ms      = (k == 2) ? 10'(DLY_REF_MS)
                              : 10'(LINE_ON_MS - 2 * DLY_REF_MS - DLY_LONG_MS);
         end
         default: s = '0;
      endcase
      return s;
   endfunction

   function automatic dps_step_t default_step(input int i);
      dps_act_t d;
      dps_act_t ab;
      dps_act_t ln;
      d  = '0;
      ab = '0;
      ln = '0;
      d.spk_classd  = 1'b1;
      ab.spk_classab = 1'b1;
      ln.line_en    = 1'b1;
      if (i >= int'(IDX_CLASSAB_OFF)) begin
         return off_step(i - int'(IDX_CLASSAB_OFF), ab, CLASSAB_OFF_MS);
      end else if (i >= int'(IDX_CLASSAB_ON)) begin
         return on_step(i - int'(IDX_CLASSAB_ON), ab, CLASSAB_ON_MS);
      end else if (i >= int'(IDX_LINE_OFF)) begin
         return off_step(i - int'(IDX_LINE_OFF), ln, LINE_OFF_MS);
      end else if (i >= int'(IDX_LINE_ON)) begin
         return line_on_step(i - int'(IDX_LINE_ON));
      end else if (i >= int'(IDX_CLASSD_OFF)) begin
         return off_step(i - int'(IDX_CLASSD_OFF), d, CLASSD_OFF_MS);
      end
      return on_step(i - int'(IDX_CLASSD_ON), d, CLASSD_ON_MS);
   endfunction

   // Supply monitors, power-on reset
   logic ana_s1_q;
   logic ana_s2_q;
   logic core_s1_q;
   logic core_s2_q;
   logic por_n_q;
   logic rst_int;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ana_s1_q  <= 1'b0;
         ana_s2_q  <= 1'b0;
         core_s1_q <= 1'b0;
         core_s2_q <= 1'b0;
         por_n_q   <= 1'b0;
      end else begin
         ana_s1_q  <= analogue_supply_ok_in;
         ana_s2_q  <= ana_s1_q;
         core_s1_q <= core_supply_ok_in;
         core_s2_q <= core_s1_q;
         por_n_q   <= ana_s2_q & core_s2_q;
      end
   end

   assign rst_int              = srst_in | ~por_n_q;
   assign power_on_reset_n_out = por_n_q;

   // Bus decode
   dps_state_t           state_q;
   logic                 busy;
   logic                 ack_q;
   logic                 req;
   logic                 wr;
   logic                 wr_ctrl;
   logic [15:0]          ctrl_q;
   logic [15:0]          new_ctrl;
   logic                 launch;
   logic                 abort_req;
   logic                 seq_end;
   logic [IDX_W-1:0]     idx_q;
   logic [9:0]           delay_q;
   logic [15:0]          tick_q;
   logic                 eos_q;
   dps_act_t             act_q;
   logic [IRQ_W-1:0]     irq_stat_q;
   logic [IRQ_W-1:0]     irq_en_q;
   logic [IDX_W-1:0]     mem_adr_q;
   dps_step_t            mem [MEM_DEPTH];
   logic [31:0]          rd_data;

   assign busy      = (state_q != S_IDLE);
   assign req       = wb_cyc_in & wb_stb_in & ~ack_q;
   assign wr        = wb_cyc_in & wb_stb_in & ack_q & wb_we_in & por_n_q;
   assign wr_ctrl   = wr && (wb_adr_in == ADR_SEQ_CTRL);
   assign new_ctrl  = {wb_sel_in[1] ? wb_dat_in[15:8] : ctrl_q[15:8],
                       wb_sel_in[0] ? wb_dat_in[7:0] : ctrl_q[7:0]};
   assign launch    = wr_ctrl && !busy && new_ctrl[CTRL_EN_BIT]
                      && new_ctrl[CTRL_START_BIT];
   assign abort_req = wr_ctrl && busy && wb_sel_in[1] && wb_dat_in[CTRL_ABORT_BIT];
   assign seq_end   = (state_q == S_WAIT) && (delay_q == 10'h000) && eos_q;

   // Control register; only abort is heeded while busy
   always_ff @(posedge clock_in) begin
      if (rst_int) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl && !busy) begin
         ctrl_q                 <= new_ctrl;
         ctrl_q[CTRL_ABORT_BIT] <= 1'b0;
         ctrl_q[CTRL_START_BIT] <= launch;
      end else if (seq_end || abort_req) begin
         ctrl_q[CTRL_START_BIT] <= 1'b0;
      end
   end

   // Sequencer engine
   always_ff @(posedge clock_in) begin
      if (rst_int) begin
         state_q <= S_IDLE;
         idx_q   <= '0;
         delay_q <= '0;
         tick_q  <= '0;
         eos_q   <= 1'b0;
         act_q   <= '0;
      end else if (abort_req) begin
         state_q <= S_IDLE;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (launch) begin
                  idx_q   <= new_ctrl[IDX_W-1:0];
                  state_q <= S_LOAD;
               end
            end
            S_LOAD: begin
               act_q   <= mem[idx_q].act;
               delay_q <= mem[idx_q].delay_ms;
               eos_q   <= mem[idx_q].eos;
               tick_q  <= '0;
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (delay_q != 10'h000) begin
                  if (tick_q == UNIT_LAST) begin
                     tick_q  <= '0;
                     delay_q <= delay_q - 10'h001;
                  end else begin
                     tick_q <= tick_q + 16'h0001;
                  end
               end else if (eos_q) begin
                  state_q <= S_IDLE;
               end else begin
                  idx_q   <= idx_q + 7'h01;
                  state_q <= S_LOAD;
               end
            end
         endcase
      end
   end

   // Step memory, refilled with the stored sequences on every reset
   always_ff @(posedge clock_in) begin
      if (rst_int) begin
         mem_adr_q <= MEM_ADR_RST;
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= default_step(i);
         end
      end else if (wr && !busy && wb_adr_in == ADR_MEM_ADR) begin
         mem_adr_q <= wb_dat_in[IDX_W-1:0];
      end else if (wr && !busy && wb_adr_in == ADR_MEM_DAT) begin
         mem[mem_adr_q] <= wb_dat_in[STEP_W-1:0];
      end
   end

   // Interrupt status: set wins over clear
   always_ff @(posedge clock_in) begin
      if (rst_int) begin
         irq_stat_q <= '0;
         irq_en_q   <= IRQ_EN_RST;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr && wb_adr_in == ADR_IRQ_CLR && wb_sel_in[0])
                                      ? wb_dat_in[IRQ_W-1:0] : '0))
                       | {abort_req, seq_end};
         if (wr && wb_adr_in == ADR_IRQ_EN && wb_sel_in[0]) begin
            irq_en_q <= wb_dat_in[IRQ_W-1:0];
         end
      end
   end

   always_comb begin
      rd_data = '0;
      unique case (wb_adr_in)
         ADR_SEQ_CTRL: rd_data[15:0] = ctrl_q;
         ADR_SEQ_STAT: begin
            rd_data[STAT_IDX_LSB +: IDX_W] = idx_q;
            rd_data[STAT_BUSY_BIT]         = busy;
         end
         ADR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q;
         ADR_IRQ_EN:   rd_data[IRQ_W-1:0] = irq_en_q;
         ADR_MEM_ADR:  rd_data[IDX_W-1:0] = mem_adr_q;
         ADR_MEM_DAT:  rd_data[STEP_W-1:0] = mem[mem_adr_q];
         default:      rd_data = '0;
      endcase
   end

   // Bus answer, one cycle after the request; acked even in power-on reset, not in srst_in
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ack_q      <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         ack_q      <= req;
         wb_dat_out <= rd_data;
      end
   end

   assign wb_ack_out                 = ack_q;
   assign act_out                    = act_q;
   assign sequencer_running_flag_out = busy;
   assign irq_out                    = |(irq_stat_q & irq_en_q);

   default clocking cb @(posedge clock_in);
   endclocking

   property p_classd_launch;
      disable iff (rst_int)
      wr_ctrl && !busy && wb_sel_in[1:0] == 2'b11 && wb_dat_in[15:0] == LAUNCH_CLASSD_ON
      |=> busy && idx_q == IDX_CLASSD_ON ##1 idx_q == IDX_CLASSD_ON;
   endproperty
   a_classd_launch: assert property (p_classd_launch)
      else $error("Class D enable launch not at index zero");

   property p_launch_index;
      disable iff (rst_int)
      launch |=> busy && idx_q == $past(new_ctrl[IDX_W-1:0]);
   endproperty
   a_launch_index: assert property (p_launch_index)
      else $error("Launch did not start at written index");

   property p_start_cleared;
      disable iff (rst_int)
      $fell(busy) |-> !ctrl_q[CTRL_START_BIT];
   endproperty
   a_start_cleared: assert property (p_start_cleared)
      else $error("Start bit left set after sequence end");

   property p_classd_on_end;
      disable iff (rst_int)
      seq_end && ctrl_q[IDX_W-1:0] == IDX_CLASSD_ON
      |-> act_q.spk_classd && act_q.dac_en && act_q.midrail_reference_soft && act_q.line_clamp;
   endproperty
   a_classd_on_end: assert property (p_classd_on_end)
      else $error("Class D enable ended in wrong state");

   property p_classd_off_end;
      disable iff (rst_int)
      seq_end && ctrl_q[IDX_W-1:0] == IDX_CLASSD_OFF
      |-> !act_q.spk_classd && !act_q.dac_en && !act_q.bias_en && act_q.line_discharge;
   endproperty
   a_classd_off_end: assert property (p_classd_off_end)
      else $error("Class D disable ended in wrong state");

   property p_por_low;
      disable iff (srst_in)
      !(ana_s2_q && core_s2_q) |=> !por_n_q;
   endproperty
   a_por_low: assert property (p_por_low)
      else $error("Reset released with a supply low");

   property p_por_writes;
      disable iff (srst_in)
      !por_n_q && wb_cyc_in && wb_stb_in && wb_we_in
      |=> ctrl_q == CTRL_RST && !busy && irq_en_q == IRQ_EN_RST;
   endproperty
   a_por_writes: assert property (p_por_writes)
      else $error("Write took effect during power-on reset");

   property p_por_release;
      disable iff (srst_in)
      $rose(por_n_q) |-> ctrl_q == CTRL_RST && irq_en_q == IRQ_EN_RST
                         && mem_adr_q == MEM_ADR_RST && !busy;
   endproperty
   a_por_release: assert property (p_por_release)
      else $error("Registers not at defaults after reset release");

endmodule

//--- dps_host.sv
// Host model: Wishbone master that stays off the bus while busy, except for urgent access
`timescale 1ns/1ns
module dps_host (
   input  wire logic        clock_in,
   input  wire logic        wb_ack_in,
   input  wire logic [31:0] wb_dat_in,
   input  wire logic        busy_in,
   output logic             wb_cyc_out,
   output logic             wb_stb_out,
   output logic             wb_we_out,
   output logic [7:0]       wb_adr_out,
   output logic [3:0]       wb_sel_out,
   output logic [31:0]      wb_dat_out
);
   initial begin
      wb_cyc_out = 1'b0;
      wb_stb_out = 1'b0;
      wb_we_out  = 1'b0;
      wb_adr_out = 8'h00;
      wb_sel_out = 4'h0;
      wb_dat_out = 32'h0000_0000;
   end

   // Urgent access skips the idle wait; only an abort uses it
   task automatic xfer(input bit now, input logic we, input logic [7:0] adr,
                       input logic [15:0] wd, output logic [15:0] rd, output bit ok);
      int n;
      ok = 1'b0;
      rd = 16'h0000;
      for (n = 0; n < 20000 && !now; n++) begin
         @(posedge clock_in);
         if (busy_in === 1'b0) break;
      end
      if (!now && busy_in !== 1'b0) return;
      @(posedge clock_in);
      wb_cyc_out <= 1'b1;
      wb_stb_out <= 1'b1;
      wb_we_out  <= we;
      wb_adr_out <= adr;
      wb_sel_out <= 4'hF;
      wb_dat_out <= {16'h0000, wd};
      for (n = 0; n < 64; n++) begin
         @(posedge clock_in);
         if (wb_ack_in === 1'b1) begin
            rd = wb_dat_in[15:0];
            ok = 1'b1;
            break;
         end
      end
      wb_cyc_out <= 1'b0;
      wb_stb_out <= 1'b0;
      wb_we_out  <= 1'b0;
      wb_dat_out <= ~{16'h0000, wd};
   endtask
endmodule

//--- dps_sequencer_tb.sv
// Self-checking bench for the power sequence launcher
`timescale 1ns/1ns
module dps_sequencer_tb;
   import dps_pkg::*;
   localparam int UNIT = 2;
   typedef struct {
      logic [15:0] word;
      logic [6:0]  idx;
      int          ms;
      int          steps;
      logic [8:0]  val;
      logic [8:0]  mask;
   } dps_row_t;
   dps_row_t rows [6] = '{
      '{LAUNCH_CLASSD_ON, IDX_CLASSD_ON, CLASSD_ON_MS, 4, 9'h0D2, 9'h0D2},
      '{LAUNCH_CLASSD_OFF, IDX_CLASSD_OFF, CLASSD_OFF_MS, 3, 9'h001, 9'h159},
      '{LAUNCH_LINE_ON, IDX_LINE_ON, LINE_ON_MS, 4, 9'h094, 9'h094},
      '{LAUNCH_LINE_OFF, IDX_LINE_OFF, LINE_OFF_MS, 3, 9'h001, 9'h11D},
      '{LAUNCH_CLASSAB_ON, IDX_CLASSAB_ON, CLASSAB_ON_MS, 4, 9'h0B2, 9'h0B2},
      '{LAUNCH_CLASSAB_OFF, IDX_CLASSAB_OFF, CLASSAB_OFF_MS, 3, 9'h001, 9'h139}
   };
   logic [7:0]  regs [5] = '{ADR_SEQ_CTRL, ADR_SEQ_STAT, ADR_IRQ_STAT, ADR_IRQ_EN, ADR_MEM_ADR};
   logic        clock_in = 1'b0;
   logic        srst_in  = 1'b1;
   logic        ana_ok   = 1'b1;
   logic        core_ok  = 1'b1;
   logic        cyc, stb, we, ack, por_n, busy, irq;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   dps_act_t    act;
   int          n_fail   = 0;
   int          n_tests  = 0;

   always #50 clock_in = ~clock_in;

   dps_sequencer #(.UNIT_CYCLES(UNIT)) dut (
      .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_ack_out(ack), .wb_dat_out(rdat), .analogue_supply_ok_in(ana_ok),
      .core_supply_ok_in(core_ok), .power_on_reset_n_out(por_n), .act_out(act),
      .sequencer_running_flag_out(busy), .irq_out(irq));

   dps_host host (
      .clock_in(clock_in), .wb_ack_in(ack), .wb_dat_in(rdat), .busy_in(busy),
      .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr),
      .wb_sel_out(sel), .wb_dat_out(wdat));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_tests++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic acc(input bit now, input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] r);
      bit ok;
      host.xfer(now, w, a, d, r, ok);
      if (!ok) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         finish_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] r;
      acc(1'b0, 1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] r;
      acc(1'b0, 1'b0, a, 16'h0000, r);
      chk(r, e);
   endtask

   // Counts busy cycles; notes a discharge seen while the line is off
   task automatic run(input int lim, output int cnt, output bit dis);
      dis = 1'b0;
      for (cnt = 0; cnt < lim; cnt++) begin
         @(posedge clock_in);
         if (busy === 1'b0) return;
         if (act.line_discharge === 1'b1 && act.line_en === 1'b0) dis = 1'b1;
      end
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, busy, 1'b0);
      finish_test();
   endtask

   initial begin
      repeat (100000) @(posedge clock_in);
      n_fail++;
      finish_test();
   end

   initial begin
      int i;
      int cnt;
      bit dis;
      logic [15:0] r;
      repeat (10) @(posedge clock_in);
      srst_in <= 1'b0;
      for (i = 0; i < 20 && por_n !== 1'b1; i++) @(posedge clock_in);
      chk({15'h0000, por_n}, 16'h0001);
      foreach (regs[k]) rdc(regs[k], 16'h0000);
      $display("Test reset defaults done");
      wr(ADR_IRQ_EN, 16'h0001);
      foreach (rows[k]) begin
         wr(ADR_SEQ_CTRL, rows[k].word);
         #1 chk({15'h0000, busy}, 16'h0001);
         run(20000, cnt, dis);
         chk_rng(cnt, rows[k].ms * UNIT - 2, rows[k].ms * UNIT + 2 * rows[k].steps + 4);
         if (k == 2) chk({15'h0000, dis}, 16'h0001);
         chk({7'h00, act & rows[k].mask}, {7'h00, rows[k].val});
         chk({15'h0000, irq}, 16'h0001);
         rdc(ADR_SEQ_STAT, {5'h00, rows[k].idx + 7'(rows[k].steps - 1), 4'h0});
         rdc(ADR_SEQ_CTRL, 16'h8000 | {9'h000, rows[k].idx});
         rdc(ADR_IRQ_STAT, 16'h0001);
         wr(ADR_IRQ_CLR, 16'h0001);
         #1 chk({15'h0000, irq}, 16'h0000);
         $display("Test launch %h done", rows[k].word);
      end
      // Masked completion, then a launch without the enable bit
      wr(ADR_IRQ_EN, 16'h0000);
      wr(ADR_SEQ_CTRL, LAUNCH_CLASSD_ON);
      run(20000, cnt, dis);
      chk({15'h0000, irq}, 16'h0000);
      rdc(ADR_IRQ_STAT, 16'h0001);
      wr(ADR_IRQ_CLR, 16'h0003);
      wr(ADR_SEQ_CTRL, 16'h0100);
      #1 chk({15'h0000, busy}, 16'h0000);
      rdc(ADR_SEQ_CTRL, 16'h0000);
      $display("Test masked irq and disabled launch done");
      // Abort in mid-run; status register ignores writes
      wr(ADR_IRQ_EN, 16'h0003);
      wr(ADR_SEQ_CTRL, LAUNCH_LINE_ON);
      repeat (10) @(posedge clock_in);
      acc(1'b1, 1'b1, ADR_SEQ_CTRL, 16'h8200, r);
      run(5, cnt, dis);
      rdc(ADR_IRQ_STAT, 16'h0002);
      chk({15'h0000, irq}, 16'h0001);
      wr(ADR_IRQ_STAT, 16'hFFFF);
      rdc(ADR_IRQ_STAT, 16'h0002);
      rdc(8'h1C, 16'h0000);
      wr(ADR_IRQ_CLR, 16'h0003);
      wr(ADR_MEM_ADR, 16'h007F);
      wr(ADR_MEM_DAT, 16'h1234);
      rdc(ADR_MEM_DAT, 16'h1234);
      rdc(ADR_MEM_ADR, 16'h007F);
      $display("Test abort and read-only status done");
      // Each supply in turn drops and returns
      for (i = 0; i < 2; i++) begin
         wr(ADR_IRQ_EN, 16'h0003);
         wr(ADR_MEM_ADR, 16'h007F);
         ana_ok  <= (i != 0);
         core_ok <= (i == 0);
         for (cnt = 0; cnt < 6 && por_n !== 1'b0; cnt++) @(posedge clock_in);
         chk({15'h0000, por_n}, 16'h0000);
         wr(ADR_IRQ_EN, 16'h0003);
         rdc(ADR_IRQ_EN, 16'h0000);
         ana_ok  <= 1'b1;
         core_ok <= 1'b1;
         for (cnt = 0; cnt < 6 && por_n !== 1'b1; cnt++) @(posedge clock_in);
         chk({15'h0000, por_n}, 16'h0001);
         rdc(ADR_IRQ_EN, 16'h0000);
         rdc(ADR_MEM_ADR, 16'h0000);
         wr(ADR_IRQ_EN, 16'h0001);
         rdc(ADR_IRQ_EN, 16'h0001);
      end
      $display("Test power-on reset done");
      finish_test();
   end
endmodule
